/* logic/spf_cfg.svh */
// Offsets, field positions, reset values and timing for the P/PI mode switch
// and torque reference filter chain. Assumes a 32-bit word register port.
`ifndef SPF_CFG_SVH
`define SPF_CFG_SVH

// Register byte offsets
`define SPF_A_SEL      8'h00
`define SPF_A_TQ_THR   8'h04
`define SPF_A_SPD_THR  8'h08
`define SPF_A_ACC_THR  8'h0C
`define SPF_A_PE_THR   8'h10
`define SPF_A_LAG_TC   8'h14
`define SPF_A_SOS_FRQ  8'h18
`define SPF_A_SOS_Q    8'h1C
`define SPF_A_NEN      8'h20
`define SPF_A_N1_FRQ   8'h24
`define SPF_A_N1_Q     8'h28
`define SPF_A_N1_DEP   8'h2C
`define SPF_A_N2_FRQ   8'h30
`define SPF_A_N2_Q     8'h34
`define SPF_A_N2_DEP   8'h38
`define SPF_A_STATUS   8'h3C

// Switch condition codes (lowest digit); notch enable code (nen digits 0 and 2)
`define SPF_SW_TORQUE  4'h0
`define SPF_SW_SPEED   4'h1
`define SPF_SW_ACCEL   4'h2
`define SPF_SW_POSERR  4'h3
`define SPF_SW_OFF     4'h4
`define SPF_NOTCH_ON   4'h1

// Reset values
`define SPF_RST_SEL    16'h0000
`define SPF_RST_TQ     16'h00C8
`define SPF_RST_SPD    16'h0000
`define SPF_RST_ACC    16'h0000
`define SPF_RST_PE     32'h0000_0000
`define SPF_RST_LAG    16'h0064
`define SPF_RST_FRQ    16'h1388
`define SPF_RST_SOSQ   16'h0032
`define SPF_RST_NEN    16'h0000
`define SPF_RST_NQ     16'h0046
`define SPF_RST_DEP    16'h0000

// Timing and fixed-point scaling
`define SPF_TS_NS      64'h0000_0000_0000_3E80
`define SPF_NS_PER_S   64'h0000_0000_3B9A_CA00
`define SPF_LAG_UNIT   64'h0000_0000_0000_2710
`define SPF_TWO_PI_Q16 64'h0000_0000_0006_487F
`define SPF_Q_ONE_Q16  32'h0064_0000
`define SPF_DEP_FULL   32'h0000_03E8
`define SPF_BYPASS_FRQ 16'h1388

`endif

/* logic/spf_pkg.sv */
// Types shared by the mode switch and filter chain.
// Assumes spf_cfg.svh carries every number.
package spf_pkg;
  typedef enum logic [2:0] {
    SPF_IDLE = 3'b000,
    SPF_LAG  = 3'b001,
    SPF_SOS  = 3'b010,
    SPF_N1   = 3'b011,
    SPF_N2   = 3'b100
  } spf_phase_t;

  typedef struct packed {
    logic signed [31:0] lp;
    logic signed [31:0] bp;
  } spf_svf_t;

  typedef struct packed {
    logic [15:0]        sel;
    logic [15:0]        tq_thr;
    logic [15:0]        spd_thr;
    logic [15:0]        acc_thr;
    logic [31:0]        pe_thr;
    logic [15:0]        lag_tc;
    logic [15:0]        sos_frq;
    logic [15:0]        sos_q;
    logic [15:0]        nen;
    logic [15:0]        n1_frq;
    logic [15:0]        n1_q;
    logic [15:0]        n1_dep;
    logic [15:0]        n2_frq;
    logic [15:0]        n2_q;
    logic [15:0]        n2_dep;
    spf_phase_t         phase;
    logic signed [31:0] x;
    logic signed [31:0] lag_y;
    logic signed [31:0] work;
    spf_svf_t           sos;
    spf_svf_t           n1;
    spf_svf_t           n2;
    logic signed [15:0] tout;
    logic               tout_valid;
    logic               p_control;
    logic [31:0]        rdata;
  } spf_state_t;
endpackage

/* logic/spf_top.sv */
// P/PI mode switch and torque reference filter chain for a servo speed loop.
// Assumes synchronous inputs on clk, one sample per control cycle on
// tref_valid, and a host that writes the settings over the register port.
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "spf_cfg.svh"

module spf_top (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  input  wire logic               pos_ctrl_mode,
  input  wire logic signed [15:0] torque_ref,
  input  wire logic signed [15:0] speed_ref,
  input  wire logic signed [15:0] accel_ref,
  input  wire logic signed [31:0] pos_err,
  input  wire logic               tref_valid,
  input  wire logic signed [15:0] tref_in,
  output logic                    tref_ready,
  output logic signed [15:0]      tout,
  output logic                    tout_valid,
  output logic                    p_control
);

  spf_pkg::spf_state_t r;
  spf_pkg::spf_state_t next_r;

  // Magnitude of a signed value
  function automatic logic [31:0] mag(input logic signed [31:0] v);
    return v[31] ? 32'(-v) : 32'(v);
  endfunction

  // Signed value times unsigned Q16 coefficient
  function automatic logic signed [31:0] mulq(input logic signed [31:0] a,
                                              input logic [31:0] c);
    logic signed [63:0] p;
    p = $signed({{32{a[31]}}, a}) * $signed({32'h0, c});
    return p[47:16];
  endfunction

  // Small-angle state-variable frequency term, 2*pi*f*Ts in Q16
  function automatic logic [31:0] f_coef(input logic [15:0] frq);
    logic [63:0] t;
    t = {48'h0, frq} * `SPF_TWO_PI_Q16 * `SPF_TS_NS / `SPF_NS_PER_S;
    return t[31:0];
  endfunction

  // Damping 1/Q in Q16; Q is in hundredths
  function automatic logic [31:0] q_coef(input logic [15:0] q);
    return `SPF_Q_ONE_Q16 / {16'h0, (q == 16'h0000) ? 16'h0001 : q};
  endfunction

  // Lag gain Ts/(Ts+T) in Q16; zero time constant passes straight through
  function automatic logic [31:0] lag_k(input logic [15:0] tc);
    logic [63:0] t;
    t = (`SPF_TS_NS << 16) / (`SPF_TS_NS + {48'h0, tc} * `SPF_LAG_UNIT);
    return t[31:0];
  endfunction

  // One state-variable filter step; lp is the low-pass output
  function automatic spf_pkg::spf_svf_t svf(input logic signed [31:0] x,
                                            input spf_pkg::spf_svf_t s,
                                            input logic [31:0] f,
                                            input logic [31:0] q);
    spf_pkg::spf_svf_t o;
    logic signed [31:0] hp;
    o.lp = s.lp + mulq(s.bp, f);
    hp   = x - o.lp - mulq(s.bp, q);
    o.bp = s.bp + mulq(hp, f);
    return o;
  endfunction

  // Notch output x - (1-depth)*bp/Q; depth 0 gives the deepest cut
  function automatic logic signed [31:0] notch(input logic signed [31:0] x,
                                               input spf_pkg::spf_svf_t s,
                                               input logic [15:0] q,
                                               input logic [15:0] dep);
    logic signed [31:0] cut;
    logic signed [63:0] p;
    cut = mulq(s.bp, q_coef(q));
    p = $signed({{32{cut[31]}}, cut}) *
        $signed({48'h0, 16'(`SPF_DEP_FULL) - dep});
    return x - 32'(p / 64'sd1000);
  endfunction

  // Drop the 8 fraction bits and clamp into 16 bits
  function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
    logic signed [31:0] s;
    s = v >>> 8;
    if (s > 32'sd32767) return 16'sh7FFF;
    if (s < -32'sd32768) return 16'sh8000;
    return s[15:0];
  endfunction

  // Readback value of one register word; unmapped words read zero
  function automatic logic [31:0] rd_word(input spf_pkg::spf_state_t s,
                                          input logic [7:0] a);
    unique case (a)
      `SPF_A_SEL:     return {16'h0, s.sel};
      `SPF_A_TQ_THR:  return {16'h0, s.tq_thr};
      `SPF_A_SPD_THR: return {16'h0, s.spd_thr};
      `SPF_A_ACC_THR: return {16'h0, s.acc_thr};
      `SPF_A_PE_THR:  return s.pe_thr;
      `SPF_A_LAG_TC:  return {16'h0, s.lag_tc};
      `SPF_A_SOS_FRQ: return {16'h0, s.sos_frq};
      `SPF_A_SOS_Q:   return {16'h0, s.sos_q};
      `SPF_A_NEN:     return {16'h0, s.nen};
      `SPF_A_N1_FRQ:  return {16'h0, s.n1_frq};
      `SPF_A_N1_Q:    return {16'h0, s.n1_q};
      `SPF_A_N1_DEP:  return {16'h0, s.n1_dep};
      `SPF_A_N2_FRQ:  return {16'h0, s.n2_frq};
      `SPF_A_N2_Q:    return {16'h0, s.n2_q};
      `SPF_A_N2_DEP:  return {16'h0, s.n2_dep};
      `SPF_A_STATUS:  return {28'h0, s.phase != spf_pkg::SPF_IDLE,
                              s.phase == spf_pkg::SPF_IDLE, 1'b0,
                              s.p_control};
      default:        return 32'h0000_0000;
    endcase
  endfunction

  logic n1_on, n2_on, pe_armed;
  assign n1_on = r.nen[3:0] == `SPF_NOTCH_ON;
  assign n2_on = r.nen[11:8] == `SPF_NOTCH_ON;
  assign pe_armed = pos_ctrl_mode;

  // Next state: register port, mode switch, one filter stage per cycle
  always_comb begin
    next_r = r;
    next_r.tout_valid = 1'b0;
    next_r.rdata = reg_rd ? rd_word(r, reg_addr) : 32'h0000_0000;
    // Settings are used straight from the registers, so a write counts
    // from the next clock on, even in the middle of a sample, without any restart
    if (reg_wr) begin
      unique case (reg_addr)
        `SPF_A_SEL:     next_r.sel     = reg_wdata[15:0];
        `SPF_A_TQ_THR:  next_r.tq_thr  = reg_wdata[15:0];
        `SPF_A_SPD_THR: next_r.spd_thr = reg_wdata[15:0];
        `SPF_A_ACC_THR: next_r.acc_thr = reg_wdata[15:0];
        `SPF_A_PE_THR:  next_r.pe_thr  = reg_wdata;
        `SPF_A_LAG_TC:  next_r.lag_tc  = reg_wdata[15:0];
        `SPF_A_SOS_FRQ: next_r.sos_frq = reg_wdata[15:0];
        `SPF_A_SOS_Q:   next_r.sos_q   = reg_wdata[15:0];
        `SPF_A_NEN:     next_r.nen     = reg_wdata[15:0];
        `SPF_A_N1_FRQ:  next_r.n1_frq  = reg_wdata[15:0];
        `SPF_A_N1_Q:    next_r.n1_q    = reg_wdata[15:0];
        `SPF_A_N1_DEP:  next_r.n1_dep  = reg_wdata[15:0];
        `SPF_A_N2_FRQ:  next_r.n2_frq  = reg_wdata[15:0];
        `SPF_A_N2_Q:    next_r.n2_q    = reg_wdata[15:0];
        `SPF_A_N2_DEP:  next_r.n2_dep  = reg_wdata[15:0];
        default:        next_r.sel     = r.sel;
      endcase
    end
    // Mode switch; codes above 4 behave as off
    unique case (r.sel[3:0])
      `SPF_SW_TORQUE: next_r.p_control =
        mag(32'(torque_ref)) > {16'h0, r.tq_thr};
      `SPF_SW_SPEED:  next_r.p_control =
        mag(32'(speed_ref)) > {16'h0, r.spd_thr};
      `SPF_SW_ACCEL:  next_r.p_control =
        mag(32'(accel_ref)) > {16'h0, r.acc_thr};
      `SPF_SW_POSERR: next_r.p_control =
        pe_armed && mag(pos_err) > r.pe_thr;
      default:        next_r.p_control = 1'b0;
    endcase
    // Filter chain, one stage per clock; samples are refused while busy
    unique case (r.phase)
      spf_pkg::SPF_IDLE: begin
        if (tref_valid) begin
          next_r.x = {{8{tref_in[15]}}, tref_in, 8'h00};
          next_r.phase = spf_pkg::SPF_LAG;
        end
      end
      spf_pkg::SPF_LAG: begin
        next_r.lag_y = r.lag_y + mulq(r.x - r.lag_y, lag_k(r.lag_tc));
        next_r.phase = spf_pkg::SPF_SOS;
      end
      spf_pkg::SPF_SOS: begin
        if (r.sos_frq == `SPF_BYPASS_FRQ) begin
          next_r.work = r.lag_y;
        end else begin
          next_r.sos = svf(r.lag_y, r.sos, f_coef(r.sos_frq),
                           q_coef(r.sos_q));
          next_r.work = next_r.sos.lp;
        end
        next_r.phase = spf_pkg::SPF_N1;
      end
      spf_pkg::SPF_N1: begin
        if (n1_on) begin
          next_r.work = notch(r.work, r.n1, r.n1_q, r.n1_dep);
          next_r.n1 = svf(r.work, r.n1, f_coef(r.n1_frq), q_coef(r.n1_q));
        end
        next_r.phase = spf_pkg::SPF_N2;
      end
      spf_pkg::SPF_N2: begin
        if (n2_on) begin
          next_r.tout = sat16(notch(r.work, r.n2, r.n2_q, r.n2_dep));
          next_r.n2 = svf(r.work, r.n2, f_coef(r.n2_frq), q_coef(r.n2_q));
        end else begin
          next_r.tout = sat16(r.work);
        end
        next_r.tout_valid = 1'b1;
        next_r.phase = spf_pkg::SPF_IDLE;
      end
      default: next_r.phase = spf_pkg::SPF_IDLE;
    endcase
  end

  // State register with synchronous reset to the default settings
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
      r.sel <= `SPF_RST_SEL;
      r.tq_thr <= `SPF_RST_TQ;
      r.spd_thr <= `SPF_RST_SPD;
      r.acc_thr <= `SPF_RST_ACC;
      r.pe_thr <= `SPF_RST_PE;
      r.lag_tc <= `SPF_RST_LAG;
      r.sos_frq <= `SPF_RST_FRQ;
      r.sos_q <= `SPF_RST_SOSQ;
      r.nen <= `SPF_RST_NEN;
      r.n1_frq <= `SPF_RST_FRQ;
      r.n1_q <= `SPF_RST_NQ;
      r.n1_dep <= `SPF_RST_DEP;
      r.n2_frq <= `SPF_RST_FRQ;
      r.n2_q <= `SPF_RST_NQ;
      r.n2_dep <= `SPF_RST_DEP;
      r.phase <= spf_pkg::SPF_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // Outputs
  assign reg_rdata = r.rdata;
  assign tref_ready = r.phase == spf_pkg::SPF_IDLE;
  assign tout = r.tout;
  assign tout_valid = r.tout_valid;
  assign p_control = r.p_control;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_off;
    r.sel[3:0] == `SPF_SW_OFF |=> !p_control;
  endproperty
  a_off: assert property (p_off) else $error("off but P control");

  // Sampled rst skips the release edge, where the design still resets
  property p_torque;
    !rst && r.sel[3:0] == `SPF_SW_TORQUE
      && mag(32'(torque_ref)) > {16'h0, r.tq_thr} |=> p_control;
  endproperty
  a_torque: assert property (p_torque) else $error("torque miss");
  property p_speed;
    !rst && r.sel[3:0] == `SPF_SW_SPEED
      && mag(32'(speed_ref)) > {16'h0, r.spd_thr} |=> p_control;
  endproperty
  a_speed: assert property (p_speed) else $error("speed missed");
  property p_accel;
    !rst && r.sel[3:0] == `SPF_SW_ACCEL
      && mag(32'(accel_ref)) > {16'h0, r.acc_thr} |=> p_control;
  endproperty
  a_accel: assert property (p_accel) else $error("accel missed");
  property p_poserr;
    !rst && r.sel[3:0] == `SPF_SW_POSERR && pos_ctrl_mode
      && mag(pos_err) > r.pe_thr |=> p_control;
  endproperty
  a_poserr: assert property (p_poserr) else $error("poserr miss");

  property p_pe_gate;
    r.sel[3:0] == `SPF_SW_POSERR && !pos_ctrl_mode |=> !p_control;
  endproperty
  a_pe_gate: assert property (p_pe_gate) else $error("pe leaked");
  property p_pi_back;
    r.sel[3:0] == `SPF_SW_TORQUE && mag(32'(torque_ref)) <= {16'h0, r.tq_thr}
      |=> !p_control;
  endproperty
  a_pi_back: assert property (p_pi_back) else $error("PI missed");

  sequence s_take;
    tref_valid && tref_ready;
  endsequence
  sequence s_chain;
    r.phase == spf_pkg::SPF_LAG ##1 r.phase == spf_pkg::SPF_SOS
      ##1 r.phase == spf_pkg::SPF_N1 ##1 r.phase == spf_pkg::SPF_N2
      ##1 tout_valid;
  endsequence
  property p_chain;
    s_take |=> s_chain;
  endproperty
  a_chain: assert property (p_chain) else $error("chain broken");

  property p_lag_zero;
    r.phase == spf_pkg::SPF_LAG && r.lag_tc == 16'h0000
      |=> r.lag_y == $past(r.x);
  endproperty
  a_lag_zero: assert property (p_lag_zero) else $error("lag bad");

  property p_sos_bypass;
    r.phase == spf_pkg::SPF_SOS && r.sos_frq == `SPF_BYPASS_FRQ
      |=> r.work == $past(r.lag_y) && $stable(r.sos);
  endproperty
  a_sos_bypass: assert property (p_sos_bypass)
    else $error("sos not bypassed");

  property p_n1_off;
    r.phase == spf_pkg::SPF_N1 && !n1_on |=> $stable(r.work);
  endproperty
  a_n1_off: assert property (p_n1_off) else $error("notch1 on");

  property p_n2_off;
    r.phase == spf_pkg::SPF_N2 && !n2_on |=> tout == sat16($past(r.work));
  endproperty
  a_n2_off: assert property (p_n2_off) else $error("notch2 on");

endmodule

/* tb/spf_loop_model.sv */
// Far-side model: the speed loop datapath feeding the torque filter chain.
// Assumes the chain takes a sample on an edge with valid and ready high.
`timescale 1ns/1ps

module spf_loop_model (
  input  wire logic               clk,
  input  wire logic               tref_ready,
  input  wire logic signed [15:0] tout,
  input  wire logic               tout_valid,
  output logic                    tref_valid,
  output logic signed [15:0]      tref_in
);
  // Idle until the bench asks for a sample
  initial begin
    tref_valid = 1'b0;
    tref_in    = 16'sh0000;
  end

  // Offer one sample after gap cycles and hold it until taken; linger keeps
  // offering a changed value while the chain is busy, which must be ignored
  task automatic send(input logic signed [15:0] v, input int gap,
                      input int linger, output logic signed [15:0] y,
                      output int lat);
    int i;
    y   = 16'sh0000;
    lat = 0;
    repeat (gap) @(posedge clk);
    @(posedge clk);
    tref_valid <= 1'b1;
    tref_in    <= v;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (tref_ready !== 1'b1 && i < 20);
    // Stale data is inverted so it never passes for the real sample
    tref_in <= ~v;
    if (linger == 0) tref_valid <= 1'b0;
    for (i = 1; i <= 12 && lat == 0; i++) begin
      @(posedge clk);
      if (i == linger) tref_valid <= 1'b0;
      #1;
      if (tout_valid === 1'b1) begin
        y   = tout;
        lat = i + 1;
      end
    end
  endtask
endmodule

/* tb/tb.sv */
// Self-checking bench for the P/PI mode switch and torque filter chain.
// Assumes spf_top and spf_loop_model are compiled first; 100 MHz clock.
`timescale 1ns/1ps
`include "spf_cfg.svh"

module tb;
  logic               clk, rst, reg_wr, reg_rd, pos_ctrl_mode;
  logic [7:0]         reg_addr;
  logic [31:0]        reg_wdata, reg_rdata;
  logic signed [15:0] torque_ref, speed_ref, accel_ref, tref_in, tout;
  logic signed [31:0] pos_err;
  logic               tref_valid, tref_ready, tout_valid, p_control;
  int                 miscompares, checks_done;

  spf_top uut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pos_ctrl_mode(pos_ctrl_mode),
    .torque_ref(torque_ref), .speed_ref(speed_ref), .accel_ref(accel_ref),
    .pos_err(pos_err), .tref_valid(tref_valid), .tref_in(tref_in),
    .tref_ready(tref_ready), .tout(tout), .tout_valid(tout_valid),
    .p_control(p_control));

  spf_loop_model mdl (.clk(clk), .tref_ready(tref_ready), .tout(tout),
    .tout_valid(tout_valid), .tref_valid(tref_valid), .tref_in(tref_in));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Comparison helpers; case inequality so unknowns never match
  task automatic cmp32(input string n, input logic [31:0] e,
                       input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic cmp_bit(input string n, input logic e, input logic g);
    cmp32(n, {31'h0, e}, {31'h0, g});
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Register port master: one-cycle strobes, read data the cycle after
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_check(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    cmp32("reg_rdata", e, reg_rdata);
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
  endtask

  // Reset value of each word, status shows the chain idle
  function automatic logic [31:0] dflt(input int i);
    case (i)
      1:        return 32'h0000_00C8;
      5:        return 32'h0000_0064;
      6, 9, 12: return 32'h0000_1388;
      7:        return 32'h0000_0032;
      10, 13:   return 32'h0000_0046;
      15:       return 32'h0000_0004;
      default:  return 32'h0000_0000;
    endcase
  endfunction

  task automatic q_set(input int c, input int v);
    case (c)
      0:       torque_ref <= 16'(v);
      1:       speed_ref  <= 16'(v);
      2:       accel_ref  <= 16'(v);
      default: pos_err    <= v;
    endcase
  endtask

  // Change one switching quantity, check p_control one cycle later
  task automatic step_p(input int c, input int v, input logic e);
    @(posedge clk);
    q_set(c, v);
    @(posedge clk);
    #1;
    cmp_bit("p_control", e, p_control);
  endtask

  // Pass-through sample: exact value, five-cycle answer, no extra output
  task automatic pass(input logic signed [15:0] v, input int linger);
    logic signed [15:0] y;
    int                 lat;
    logic               extra;
    mdl.send(v, linger, linger, y, lat);
    cmp32("tout", 32'(v), 32'(y));
    cmp32("latency", 32'h0000_0005, 32'(lat));
    extra = 1'b0;
    repeat (6) begin
      @(posedge clk);
      #1;
      if (tout_valid !== 1'b0) extra = 1'b1;
    end
    cmp_bit("extra_tout_valid", 1'b0, extra);
  endtask

  // Constant input: does any of n outputs differ from it
  task automatic any_dev(input int n, input logic e);
    logic signed [15:0] y;
    int                 lat;
    logic               dev;
    dev = 1'b0;
    repeat (n) begin
      mdl.send(16'sh03E8, 0, 0, y, lat);
      if (y !== 16'sh03E8) dev = 1'b1;
    end
    cmp_bit("tout_deviates", e, dev);
  endtask

  task automatic t_regs();
    logic [31:0] d;
    do_reset();
    for (int i = 0; i < 16; i++) begin
      reg_check(8'(i * 4), dflt(i));
    end
    reg_check(8'h40, 32'h0000_0000);
    for (int i = 0; i < 15; i++) begin
      reg_write(8'(i * 4), 32'h5A5A_0100 + 32'(i));
    end
    // Status and unmapped places ignore writes
    reg_write(`SPF_A_STATUS, 32'hFFFF_FFFF);
    reg_write(8'h40, 32'hFFFF_FFFF);
    for (int i = 0; i < 15; i++) begin
      d = (i == 4) ? 32'h5A5A_0104 : 32'h0000_0100 + 32'(i);
      reg_check(8'(i * 4), d);
    end
    reg_check(`SPF_A_STATUS, 32'h0000_0004);
    reg_check(8'h40, 32'h0000_0000);
  endtask

  task automatic t_mode();
    do_reset();
    step_p(0, 201, 1'b1);
    step_p(0, 200, 1'b0);
    // Each code: only its own quantity counts, strictly above, by magnitude
    for (int c = 0; c < 4; c++) begin
      do_reset();
      pos_ctrl_mode <= 1'b1;
      for (int k = 0; k < 4; k++) begin
        reg_write(8'h04 + 8'(k * 4), 32'h0000_0064);
        q_set(k, (k == c) ? 0 : 900);
      end
      reg_write(`SPF_A_SEL, 32'(c));
      step_p(c, 0, 1'b0);
      step_p(c, 101, 1'b1);
      step_p(c, 100, 1'b0);
      step_p(c, -101, 1'b1);
    end
    @(posedge clk);
    pos_ctrl_mode <= 1'b0;
    step_p(3, 900, 1'b0);
    reg_write(`SPF_A_SEL, 32'h0000_0004);
    step_p(0, 900, 1'b0);
  endtask

  task automatic t_chain();
    logic signed [15:0] y;
    int                 lat;
    do_reset();
    speed_ref <= 16'sh0000;
    mdl.send(16'sh03E8, 2, 0, y, lat);
    cmp_bit("lag_partial", 1'b1,
            (y > 16'sh0000) && (y < 16'sh03E8));
    // Zero lag sits inside any stability bound on the loop gain
    reg_write(`SPF_A_LAG_TC, 32'h0000_0000);
    pass(16'sh03E8, 0);
    pass(-16'sh03E8, 0);
    pass(16'sh7FFF, 3);
    pass(16'sh8000, 0);
    reg_write(`SPF_A_SOS_FRQ, 32'h0000_03E8);
    any_dev(4, 1'b1);
    reg_write(`SPF_A_SOS_FRQ, 32'h0000_1388);
    any_dev(2, 1'b0);
    // Motor at rest, notch far above the loop response
    reg_write(`SPF_A_N1_FRQ, 32'h0000_03E8);
    reg_write(`SPF_A_NEN, 32'h0000_0001);
    any_dev(8, 1'b1);
    reg_write(`SPF_A_N1_DEP, 32'h0000_03E8);
    any_dev(2, 1'b0);
    reg_write(`SPF_A_N2_FRQ, 32'h0000_03E8);
    reg_write(`SPF_A_NEN, 32'h0000_0010);
    any_dev(2, 1'b0);
    reg_write(`SPF_A_NEN, 32'h0000_0100);
    any_dev(8, 1'b1);
    reg_write(`SPF_A_NEN, 32'h0000_0000);
    any_dev(2, 1'b0);
  endtask

  // Main sequence
  initial begin
    rst           = 1'b1;
    reg_addr      = 8'h00;
    reg_wdata     = 32'h0000_0000;
    reg_wr        = 1'b0;
    reg_rd        = 1'b0;
    pos_ctrl_mode = 1'b0;
    torque_ref    = 16'sh0000;
    speed_ref     = 16'sh0000;
    accel_ref     = 16'sh0000;
    pos_err       = 32'sh0000_0000;
    miscompares   = 0;
    checks_done   = 0;
    do_reset();
    t_regs();
    t_mode();
    t_chain();
    print_verdict();
  end

  // Watchdog: the tests need well under a thousand cycles, allow 50000
  initial begin
    #500000;
    miscompares++;
    print_verdict();
  end
endmodule
